// ---- adc_core_model.sv ----
// Purpose: converter core stand-in returning result bits serially
// Assumes: msb first, one bit per valid pulse
// Notes: slow mode spaces pulses so an abort can land between bits
module adc_core_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic convert,
  input wire logic slow,
  input wire logic [9:0] sample,
  output logic conv_bit_valid,
  output logic conv_bit
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////
  logic [3:0] idx; // bits already sent
  logic phase; // pacing in slow mode
  // bit server; the data line toggles when idle so stale bits never look good
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      idx <= 4'h0;
      phase <= 1'b0;
      conv_bit_valid <= 1'b0;
      conv_bit <= 1'b0;
    end else if (!convert) begin
      idx <= 4'h0;
      phase <= 1'b0;
      conv_bit_valid <= 1'b0;
      conv_bit <= ~conv_bit;
    end else if (idx < 4'hA && (!slow || phase)) begin
      conv_bit_valid <= 1'b1;
      conv_bit <= sample[4'h9 - idx];
      idx <= idx + 4'h1;
      phase <= 1'b0;
    end else begin
      conv_bit_valid <= 1'b0;
      conv_bit <= ~conv_bit;
      phase <= 1'b1;
    end
  end
endmodule

// ---- tb_touch_sense_sequencer.sv ----
// Purpose: self-checking bench for the touch sense sequencer
// Assumes: divider of one, so stage lengths are exact clock counts
// Notes: scenarios run in order from one reset
module tb_touch_sense_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import tss_pkg::*;
  ////////////////////////////////////////////////////////////
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic special_trigger = 1'b0;
  logic slow = 1'b0; // converter pacing
  logic [9:0] samp = 10'h000; // value the converter returns
  logic [7:0] reg_rdata;
  logic conv_bit_valid, conv_bit, conversion_done_flag;
  sensor_drive_t drive;
  int bad_count = 0;
  int num_checks = 0;
  int nbit = 0; // bits seen during conversion
  touch_sense_sequencer #(.INSTR_DIV(1)) touch_sense_sequencer_i (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_trigger(special_trigger),
    .conv_bit_valid(conv_bit_valid), .conv_bit(conv_bit),
    .conversion_done_flag(conversion_done_flag), .drive(drive));
  adc_core_model adc_core_model_i (.clk_sys(clk_sys), .reset(reset), .convert(drive.adc_convert),
    .slow(slow), .sample(samp), .conv_bit_valid(conv_bit_valid), .conv_bit(conv_bit));
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (conv_bit_valid && drive.adc_convert) nbit <= nbit + 1;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write, strobe dropped after the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic res_chk(input logic [3:0] a, input logic [9:0] s);
    rd_chk(a, s[7:0]);
    rd_chk(a + 4'h1, {6'h00, s[9:8]});
  endtask
  // check drive in this cycle, then move one cycle on
  task automatic step(input sensor_drive_t e);
    chk(drive, e);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    for (int a = 0; a < 16; a++) rd_chk(a[3:0], 8'h00);
    chk(drive, '0);
    // go refused when written with turn-on
    wr(OFS_CONTROL_ZERO, 8'h03);
    #1 chk(drive, '0);
    rd_chk(OFS_CONTROL_ZERO, 8'h01);
  endtask
  // full sequence walked cycle by cycle, one or two conversions
  task automatic run_seq(input logic [6:0] pre, input logic [6:0] acq, input logic [7:0] c3,
      input logic [7:0] grd, input logic [9:0] s0, input logic [9:0] s1);
    logic inv;
    logic g;
    int n;
    sensor_drive_t e;
    wr(OFS_CONTROL_THREE, c3);
    wr(OFS_PRECHARGE, {1'b0, pre});
    wr(OFS_ACQUISITION, {1'b0, acq});
    wr(OFS_GUARD, grd);
    wr(OFS_FLAGS, 8'h00);
    samp = s0;
    wr(OFS_CONTROL_ZERO, 8'h03);
    #1;
    for (int p = 0; p <= int'(c3[BIT_DOUBLE_SAMPLE]); p++) begin
      inv = (p == 1) && c3[BIT_INVERT_SECOND];
      g = grd[BIT_GUARD_POL] ^ inv;
      e = '0;
      e.hold_isolate = 1'b1;
      e.hold_to_supply = c3[BIT_INT_POL] ^ inv;
      e.chan_drive_en = 1'b1;
      e.chan_drive_high = c3[BIT_EXT_POL] ^ inv;
      e.mux_force_open = 1'b1;
      e.bus_pin_oe = c3[BIT_BUS_OUT_EN] & c3[BIT_OVERRIDE_EN];
      e.bus_pin_out = c3[BIT_INT_POL] ^ inv;
      e.guard_a = grd[BIT_GUARD_A_EN] & g;
      e.guard_b = grd[BIT_GUARD_B_EN] & g;
      repeat (pre) step(e);
      e = '0;
      e.chan_connect = 1'b1;
      // with no acquisition stage the ring never toggles
      e.guard_a = grd[BIT_GUARD_A_EN] & (g ^ (acq != 7'd0));
      e.guard_b = grd[BIT_GUARD_B_EN] & (g ^ (acq != 7'd0));
      repeat (acq) step(e);
      e.chan_connect = 1'b0;
      e.adc_convert = 1'b1;
      step(e);
      for (n = 0; n < 40 && drive.adc_convert; n++) step(e);
      chk(n[15:0], 16'd10);
      e.adc_convert = 1'b0;
      step(e);
      if (p == 0 && c3[BIT_DOUBLE_SAMPLE]) begin
        chk(conversion_done_flag, 1'b0);
        samp = s1;
        step(e);
      end
    end
    chk(conversion_done_flag, 1'b1);
    rd_chk(OFS_CONTROL_ZERO, 8'h01);
    res_chk(OFS_RESULT0_LOW, s0);
    if (c3[BIT_DOUBLE_SAMPLE]) res_chk(OFS_RESULT1_LOW, s1);
  endtask
  task automatic t_stages();
    run_seq(7'd3, 7'd2, 8'h0F, 8'hC1, 10'h2A5, 10'h000);
    run_seq(7'd0, 7'd4, 8'h00, 8'h80, 10'h3FF, 10'h000);
    run_seq(7'd2, 7'd0, 8'h02, 8'h40, 10'h001, 10'h000);
    run_seq(7'd1, 7'd1, 8'hC5, 8'hC1, 10'h155, 10'h2AA);
    run_seq(7'd127, 7'd1, 8'h8E, 8'h41, 10'h200, 10'h0FF);
  endtask
  // trigger start, status while busy, abort between two bits
  task automatic t_abort();
    logic [9:0] s;
    logic [9:0] e;
    int k;
    int base;
    s = 10'h2D3;
    wr(OFS_CONTROL_THREE, 8'h00);
    wr(OFS_PRECHARGE, 8'h05);
    wr(OFS_ACQUISITION, 8'h05);
    wr(OFS_FLAGS, 8'h00);
    samp = s;
    slow = 1'b1;
    base = nbit;
    special_trigger <= 1'b1;
    @(posedge clk_sys);
    special_trigger <= 1'b0;
    rd_chk(OFS_STATUS, {6'h00, STAGE_PRE});
    for (k = 0; k < 20 && !drive.adc_convert; k++) @(posedge clk_sys);
    rd_chk(OFS_STATUS, {6'h00, STAGE_CONV});
    rd_chk(OFS_CONTROL_ZERO, 8'h03);
    do @(posedge clk_sys); while (conv_bit_valid);
    wr(OFS_CONTROL_ZERO, 8'h01);
    #1 k = nbit - base;
    for (int i = 0; i < 10; i++) e[9 - i] = (i < k) ? s[9 - i] : ((k == 0) ? 1'b0 : s[10 - k]);
    res_chk(OFS_RESULT0_LOW, e);
    chk(conversion_done_flag, 1'b0);
    rd_chk(OFS_CONTROL_ZERO, 8'h01);
    slow = 1'b0;
  endtask
  // converter off during acquisition
  task automatic t_off();
    wr(OFS_GUARD, 8'hC0);
    wr(OFS_ACQUISITION, 8'h3C);
    wr(OFS_CONTROL_ZERO, 8'h03);
    repeat (8) @(posedge clk_sys);
    #1 chk(drive.guard_a & drive.guard_b & drive.chan_connect, 1'b1);
    wr(OFS_CONTROL_ZERO, 8'h00);
    #1 chk(drive, '0);
    chk(conversion_done_flag, 1'b0);
    wr(OFS_CONTROL_ZERO, 8'h01);
  endtask
  task automatic t_reset_mid();
    wr(OFS_CONTROL_ZERO, 8'h03);
    repeat (3) @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1 chk(drive, '0);
    rd_chk(OFS_CONTROL_ZERO, 8'h00);
    rd_chk(OFS_PRECHARGE, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset_values();
    t_stages();
    t_abort();
    t_off();
    t_reset_mid();
    conclude();
  end
  // watchdog at 8000 cycles, well beyond the expected few hundred
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule

// ---- touch_sense_sequencer.sv ----
// Purpose: pre-charge, acquisition and conversion sequencer for touch sensing
// Assumes: converter core returns result bits serially, most significant first
// Notes: stage times count instruction cycles made by a clock divider

// Notes on behaviour
// - pre-charge lasts programmed instruction cycles
// - zero pre-charge time skips that stage
// - start on go bit or trigger
// - hold capacitor isolated, tied per internal polarity
// - channel pin driven per external polarity
// - bus pin overridden when both enables set
// - mux forced open only in pre-charge
// - acquisition lasts programmed instruction cycles
// - acquisition follows pre-charge or start directly
// - acquisition releases channel drivers, connects channel
// - converter off halts any conversion
// - go bit reads set while busy
// - completion clears go, sets flag, stores
// - software abort stores partial, filled result
// - status register shows current stage
// - reset clears registers and cancels sequence
// - double sample gives two conversions
// - first result pair zero, second pair one
// - second sequence starts two clocks later
// - second conversion uses inverted polarities
// - guards follow polarity, toggle at acquisition
// - second guard phases inverted when enabled
module touch_sense_sequencer #(
  parameter int INSTR_DIV = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic special_trigger,
  input wire logic conv_bit_valid,
  input wire logic conv_bit,
  output logic conversion_done_flag,
  output tss_pkg::sensor_drive_t drive
);
  import tss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  // divider counter is 8 bits wide
  if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_div
    $error("INSTR_DIV must lie between 1 and 256");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // first stage of a sequence, skipping stages whose time is zero
  function automatic seq_state_t first_stage(input logic [6:0] pre_t,
                                             input logic [6:0] acq_t);
    if (pre_t != 7'h00) begin
      return ST_PRE;
    end else if (acq_t != 7'h00) begin
      return ST_ACQ;
    end else begin
      return ST_CONV;
    end
  endfunction
  // unconverted low bits copy the last bit converted
  function automatic logic [RESULT_W-1:0] fill_partial(input logic [RESULT_W-1:0] bits,
                                                        input logic [3:0] done_n,
                                                        input logic last);
    logic [RESULT_W-1:0] r;
    r = bits;
    for (int i = 0; i < RESULT_W; i++) begin
      if (i < RESULT_W - int'(done_n)) begin
        r[i] = last;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam logic [7:0] DIV_LAST = 8'(INSTR_DIV - 1);
  localparam logic [3:0] LAST_BIT = 4'(RESULT_W - 1);
  localparam logic [1:0] GAP_LAST = 2'(GAP_CYCLES - 1);
  logic [7:0] div_cnt; // instruction cycle divider
  logic instr_tick; // one-cycle enable per instruction cycle
  logic [7:0] control_zero; // converter_on lives here; go is derived
  logic [7:0] control_three; // polarities, overrides, double sample
  logic [6:0] precharge_time; // pre-charge length in instruction cycles
  logic [6:0] acquisition_time; // acquisition length in instruction cycles
  logic [7:0] guard_control; // guard enables and polarity
  logic [RESULT_W-1:0] result0; // first conversion
  logic [RESULT_W-1:0] result1; // second conversion
  seq_state_t state; // sequencer stage
  seq_state_t next_state;
  logic [6:0] stage_timer; // instruction cycles left in stage
  logic [1:0] gap_cnt; // clocks spent between conversions
  logic second; // second conversion of a double sample
  logic [3:0] bit_cnt; // result bits received so far
  logic [RESULT_W-1:0] shift_bits; // result bits in place
  logic last_bit; // last bit received
  logic guard_level; // current guard ring level
  logic next_guard_level;
  logic converter_on;
  logic on_after_write; // enable as it stands once this edge has passed
  logic busy;
  logic wr_ctrl0;
  logic sw_start;
  logic trig_start;
  logic start;
  logic sw_abort;
  logic halt;
  logic last_sample;
  logic conv_complete;
  logic invert;
  logic [1:0] stage_code;
  assign converter_on = control_zero[BIT_CONVERTER_ON];
  assign busy = (state != ST_IDLE);
  assign wr_ctrl0 = reg_wr && (reg_addr == OFS_CONTROL_ZERO);
  assign on_after_write = wr_ctrl0 ? reg_wdata[BIT_CONVERTER_ON] : converter_on;
  assign sw_start = wr_ctrl0 && reg_wdata[BIT_GO] && converter_on;
  assign trig_start = special_trigger && converter_on;
  assign start = !busy && (sw_start || trig_start);
  assign sw_abort = busy && wr_ctrl0 && !reg_wdata[BIT_GO];
  assign halt = busy && !converter_on;
  assign last_sample = conv_bit_valid && (bit_cnt == LAST_BIT);
  assign conv_complete = (state == ST_CONV) && last_sample && !halt && !sw_abort;
  assign invert = second && control_three[BIT_INVERT_SECOND]
                  && control_three[BIT_DOUBLE_SAMPLE];

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle divider
  // free-running, so the first instruction cycle of a stage may be partial
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_cnt <= 8'h00;
      instr_tick <= 1'b0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= 8'h00;
      instr_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      instr_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  // reset clears all settings
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      control_zero <= RESET_REG;
      control_three <= RESET_REG;
      precharge_time <= RESET_TIME;
      acquisition_time <= RESET_TIME;
      guard_control <= RESET_REG;
    end else if (reg_wr) begin
      case (reg_addr)
        // only the enable is stored; go is the busy state
        OFS_CONTROL_ZERO: control_zero <= {7'h00, reg_wdata[BIT_CONVERTER_ON]};
        OFS_CONTROL_THREE: control_three <= reg_wdata;
        OFS_PRECHARGE: precharge_time <= reg_wdata[6:0];
        OFS_ACQUISITION: acquisition_time <= reg_wdata[6:0];
        OFS_GUARD: guard_control <= reg_wdata;
        default: ; // other offsets hold no writable settings
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage sequencing
  // next stage from timers, converter bits and software
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = first_stage(precharge_time, acquisition_time);
        end
      end
      ST_PRE: begin
        if (instr_tick && stage_timer == 7'h01) begin
          next_state = (acquisition_time != 7'h00) ? ST_ACQ : ST_CONV;
        end
      end
      ST_ACQ: begin
        if (instr_tick && stage_timer == 7'h01) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (last_sample) begin
          next_state = (control_three[BIT_DOUBLE_SAMPLE] && !second) ? ST_GAP : ST_IDLE;
        end
      end
      ST_GAP: begin
        if (gap_cnt == GAP_LAST) begin
          next_state = first_stage(precharge_time, acquisition_time);
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // abort and halt override any stage
    if (halt || sw_abort) begin
      next_state = ST_IDLE;
    end
  end

  // stage register and stage timers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      stage_timer <= 7'h00;
      gap_cnt <= 2'h0;
    end else begin
      state <= next_state;
      if (next_state == ST_PRE && state != ST_PRE) begin
        stage_timer <= precharge_time;
      end else if (next_state == ST_ACQ && state != ST_ACQ) begin
        stage_timer <= acquisition_time;
      end else if (instr_tick && stage_timer != 7'h00) begin
        stage_timer <= stage_timer - 7'h01;
      end
      gap_cnt <= (state == ST_GAP) ? gap_cnt + 2'h1 : 2'h0;
    end
  end

  // which conversion of a double sample is running
  always_ff @(posedge clk_sys) begin
    if (reset || next_state == ST_IDLE) begin
      second <= 1'b0;
    end else if (next_state == ST_GAP) begin
      second <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result assembly and storage
  // bits land in place, most significant first; cleared between conversions
  always_ff @(posedge clk_sys) begin
    if (reset || state == ST_IDLE || state == ST_GAP) begin
      bit_cnt <= 4'h0;
      shift_bits <= '0;
      last_bit <= 1'b0;
    end else if (state == ST_CONV && conv_bit_valid && bit_cnt != 4'(RESULT_W)) begin
      shift_bits[LAST_BIT - bit_cnt] <= conv_bit;
      last_bit <= conv_bit;
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // result pairs; a halted conversion keeps the previous result, an abort stores a filled partial one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      result0 <= '0;
      result1 <= '0;
    end else if (start && control_three[BIT_DOUBLE_SAMPLE]) begin
      // second pair reads zero until its conversion lands
      result1 <= '0;
    end else if (conv_complete) begin
      if (second) begin
        result1 <= fill_partial(shift_bits, LAST_BIT, conv_bit);
      end else begin
        result0 <= fill_partial(shift_bits, LAST_BIT, conv_bit);
      end
    end else if (sw_abort && converter_on) begin
      if (second) begin
        result1 <= fill_partial(shift_bits, bit_cnt, last_bit);
      end else begin
        result0 <= fill_partial(shift_bits, bit_cnt, last_bit);
      end
    end
  end

  // done flag; a completion beats a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conversion_done_flag <= 1'b0;
    end else if (conv_complete && next_state == ST_IDLE) begin
      conversion_done_flag <= 1'b1;
    end else if (reg_wr && reg_addr == OFS_FLAGS) begin
      conversion_done_flag <= reg_wdata[BIT_DONE_FLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // guard ring level
  // level set at pre-charge start, flipped at acquisition start
  always_comb begin
    next_guard_level = guard_level;
    if (next_state == ST_PRE && state != ST_PRE) begin
      next_guard_level = guard_control[BIT_GUARD_POL] ^ invert;
    end else if (next_state == ST_ACQ && state != ST_ACQ) begin
      next_guard_level = !(guard_control[BIT_GUARD_POL] ^ invert);
    end
  end

  // ring level starts low until the first pre-charge or acquisition
  always_ff @(posedge clk_sys) begin
    guard_level <= reset ? 1'b0 : next_guard_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin, switch and converter drive
  // decoded from the next stage so every output lines up with the state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drive <= '0;
    end else begin
      drive <= '0;
      // guards live whenever enabled and on
      // follows the enable being written, so guards drop with the turn-off write
      drive.guard_a <= guard_control[BIT_GUARD_A_EN] && on_after_write && next_guard_level;
      drive.guard_b <= guard_control[BIT_GUARD_B_EN] && on_after_write && next_guard_level;
      case (next_state)
        ST_PRE: begin
          drive.hold_isolate <= 1'b1;
          drive.hold_to_supply <= control_three[BIT_INT_POL] ^ invert;
          drive.chan_drive_en <= 1'b1;
          drive.chan_drive_high <= control_three[BIT_EXT_POL] ^ invert;
          drive.mux_force_open <= 1'b1;
          drive.bus_pin_oe <= control_three[BIT_BUS_OUT_EN]
                              && control_three[BIT_OVERRIDE_EN];
          drive.bus_pin_out <= control_three[BIT_INT_POL] ^ invert;
        end
        ST_ACQ: begin
          drive.chan_connect <= 1'b1;
        end
        ST_CONV: begin
          drive.adc_convert <= 1'b1;
        end
        default: ; // idle and gap leave every override released
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port
  // stage code for status
  always_comb begin
    case (state)
      ST_PRE: stage_code = STAGE_PRE;
      ST_ACQ: stage_code = STAGE_ACQ;
      ST_CONV: stage_code = STAGE_CONV;
      default: stage_code = STAGE_IDLE;
    endcase
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (reset || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        OFS_CONTROL_ZERO: reg_rdata <= {6'h00, busy, converter_on};
        OFS_CONTROL_THREE: reg_rdata <= control_three;
        OFS_STATUS: reg_rdata <= {5'h00, second, stage_code};
        OFS_PRECHARGE: reg_rdata <= {1'b0, precharge_time};
        OFS_ACQUISITION: reg_rdata <= {1'b0, acquisition_time};
        OFS_GUARD: reg_rdata <= guard_control;
        OFS_RESULT0_LOW: reg_rdata <= result0[LOW_W-1:0];
        OFS_RESULT0_HIGH: reg_rdata <= {6'h00, result0[RESULT_W-1:LOW_W]};
        OFS_RESULT1_LOW: reg_rdata <= result1[LOW_W-1:0];
        OFS_RESULT1_HIGH: reg_rdata <= {6'h00, result1[RESULT_W-1:LOW_W]};
        OFS_FLAGS: reg_rdata <= {7'h00, conversion_done_flag};
        default: reg_rdata <= 8'h00; // unmapped offsets read zero
      endcase
    end
  end

endmodule

// ---- tss_checker.sv ----
// Purpose: port assertions for the touch sense sequencer
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound into every sequencer instance
module tss_checker #(
  parameter int INSTR_DIV = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic special_trigger,
  input wire logic conv_bit_valid,
  input wire logic conv_bit,
  input wire logic conversion_done_flag,
  input wire tss_pkg::sensor_drive_t drive
);
  timeunit 1ns;
  timeprecision 100ps;
  import tss_pkg::*;
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // software write to control zero
  logic ctl_wr;
  assign ctl_wr = reg_wr && (reg_addr == OFS_CONTROL_ZERO);
  // conversion stage just left
  sequence conv_end;
    drive.adc_convert ##1 !drive.adc_convert;
  endsequence
  // no stage active, guards may still drive
  sequence quiet;
    !drive.hold_isolate && !drive.chan_connect && !drive.adc_convert;
  endsequence
  a_pre_drive_shape: assert property (
    drive.hold_isolate |-> drive.chan_drive_en && drive.mux_force_open && !drive.chan_connect
  ) else $error("pre-charge drive shape wrong");
  a_bus_pin_pol: assert property (
    drive.bus_pin_oe |-> drive.hold_isolate && (drive.bus_pin_out == drive.hold_to_supply)
  ) else $error("bus pin override wrong");
  a_acq_release: assert property (
    drive.chan_connect |-> !drive.chan_drive_en && !drive.mux_force_open && !drive.bus_pin_oe
  ) else $error("acquisition still drives pins");
  // a flag rise that does not follow a register write must come on the last result bit
  a_done_cause: assert property (
    $rose(conversion_done_flag) && !$past(reg_wr) |->
      $past(drive.adc_convert && conv_bit_valid) ##0 quiet
  ) else $error("done flag without final bit");
  a_conv_gap_two: assert property (
    conv_end |-> quiet [*2]
  ) else $error("stage too soon after conversion");
  a_halt_when_off: assert property (
    ctl_wr && !reg_wdata[BIT_CONVERTER_ON] |=> drive == '0
  ) else $error("drive not cleared when off");
  a_abort_idle: assert property (
    ctl_wr && !reg_wdata[BIT_GO] |=> quiet
  ) else $error("abort did not stop sequence");
  a_guard_toggle: assert property (
    $rose(drive.chan_connect) && $past(drive.hold_isolate) && $past(drive.guard_a || drive.guard_b)
      |-> !drive.guard_a && !drive.guard_b
  ) else $error("guard did not toggle");
  a_rdata_once: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00
  ) else $error("read data outside its cycle");
endmodule
bind touch_sense_sequencer tss_checker #(.INSTR_DIV(INSTR_DIV)) tss_checker_i (
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_trigger(special_trigger),
  .conv_bit_valid(conv_bit_valid), .conv_bit(conv_bit),
  .conversion_done_flag(conversion_done_flag), .drive(drive)
);

// ---- tss_pkg.sv ----
// Purpose: shared constants and types of the touch sense sequencer
// Assumes: 8-bit register port, 10-bit serial result from the converter core
// Notes: offsets are register indices on the plain register port
package tss_pkg;

  // register offsets
  localparam logic [3:0] OFS_CONTROL_ZERO = 4'h0;
  localparam logic [3:0] OFS_CONTROL_THREE = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_PRECHARGE = 4'h3;
  localparam logic [3:0] OFS_ACQUISITION = 4'h4;
  localparam logic [3:0] OFS_GUARD = 4'h5;
  localparam logic [3:0] OFS_RESULT0_LOW = 4'h6;
  localparam logic [3:0] OFS_RESULT0_HIGH = 4'h7;
  localparam logic [3:0] OFS_RESULT1_LOW = 4'h8;
  localparam logic [3:0] OFS_RESULT1_HIGH = 4'h9;
  localparam logic [3:0] OFS_FLAGS = 4'hA;

  // sequencer_control_zero fields
  localparam int BIT_CONVERTER_ON = 0;
  localparam int BIT_GO = 1;
  // sequencer_control_three fields
  localparam int BIT_INT_POL = 0;
  localparam int BIT_EXT_POL = 1;
  localparam int BIT_OVERRIDE_EN = 2;
  localparam int BIT_BUS_OUT_EN = 3;
  localparam int BIT_INVERT_SECOND = 6;
  localparam int BIT_DOUBLE_SAMPLE = 7;
  // guard_control_reg fields
  localparam int BIT_GUARD_POL = 0;
  localparam int BIT_GUARD_B_EN = 6;
  localparam int BIT_GUARD_A_EN = 7;
  // peripheral_flag_reg fields
  localparam int BIT_DONE_FLAG = 0;
  // sequencer_status_reg fields
  localparam int BIT_SECOND = 2;

  // reset values
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [6:0] RESET_TIME = 7'h00;

  // converter result width and split over the two result bytes
  localparam int RESULT_W = 10;
  localparam int LOW_W = 8;

  // timing: clock rate and gap between the two conversions of a double sample
  localparam int CLK_PERIOD_NS = 25;
  localparam int GAP_CYCLES = 2;

  // stage codes shown in the status register
  localparam logic [1:0] STAGE_IDLE = 2'h0;
  localparam logic [1:0] STAGE_PRE = 2'h1;
  localparam logic [1:0] STAGE_ACQ = 2'h2;
  localparam logic [1:0] STAGE_CONV = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_ACQ,
    ST_CONV,
    ST_GAP
  } seq_state_t;

  // drive toward sample switches, sensor pins, mux and converter core
  typedef struct packed {
    logic hold_isolate;
    logic hold_to_supply;
    logic chan_drive_en;
    logic chan_drive_high;
    logic chan_connect;
    logic mux_force_open;
    logic bus_pin_oe;
    logic bus_pin_out;
    logic guard_a;
    logic guard_b;
    logic adc_convert;
  } sensor_drive_t;

endpackage
